// ### src/acs_clkdiv.sv
// conversion clock enable: source select then divide by 1, 2, 4 or 8
`timescale 1ns/1ns
module acs_clkdiv (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// control
	input wire logic run,
	input wire logic [1:0] clkSel,
	input wire logic [1:0] divSel,
	input wire logic altTick,
	// conversion clock enable
	output logic adckTick
);
	import acs_pkg::*;

	logic [2:0] preQ;
	logic [2:0] divQ;
	logic srcTick;
	logic [2:0] divMax;

	// source pulse selection
	always_comb
	begin
		unique case (clkSel)
			CLK_BUS: srcTick = 1'b1;
			CLK_BUS_HALF: srcTick = preQ[0];
			CLK_ALT: srcTick = altTick;
			CLK_ASYNC: srcTick = (preQ == 3'(ASYNC_DIV - 1));
		endcase
		divMax = 3'((4'h1 << divSel) - 4'h1);
	end

	// counters only run while converting, to save power when idle
	always_ff @(posedge clock)
	begin
		if (!rst_b || !run)
		begin
			preQ <= '0;
			divQ <= '0;
			adckTick <= 1'b0;
		end
		else
		begin
			preQ <= (preQ == 3'(ASYNC_DIV - 1)) ? 3'h0 : preQ + 3'h1;
			adckTick <= srcTick && (divQ == divMax);
			if (srcTick)
				divQ <= (divQ == divMax) ? 3'h0 : divQ + 3'h1;
		end
	end

endmodule : acs_clkdiv

// ### src/acs_pkg.sv
// constants and types shared by the conversion sequencer files
package acs_pkg;

	// ********************************
	// register word indices (byte address = 4 * index)
	// ********************************
	localparam logic [3:0] IDX_SC_FIRST = 4'h0;
	localparam logic [3:0] IDX_SC_SECOND = 4'h1;
	localparam logic [3:0] IDX_RES_HIGH = 4'h2;
	localparam logic [3:0] IDX_RES_LOW = 4'h3;
	localparam logic [3:0] IDX_CMP_HIGH = 4'h4;
	localparam logic [3:0] IDX_CMP_LOW = 4'h5;
	localparam logic [3:0] IDX_CONFIG = 4'h6;
	localparam logic [3:0] IDX_ISO_LOW = 4'h7;
	localparam logic [3:0] IDX_ISO_MID = 4'h8;
	localparam logic [3:0] IDX_ISO_HIGH = 4'h9;

	// ********************************
	// field positions
	// ********************************
	localparam int SC1_FLAG = 7;
	localparam int SC1_IRQ_EN = 6;
	localparam int SC1_CONT = 5;
	localparam int SC2_ACTIVE = 7;
	localparam int SC2_TRIG_SEL = 6;
	localparam int SC2_CMP_EN = 5;
	localparam int SC2_CMP_GT = 4;
	localparam int CFG_LONG_SAMPLE = 4;
	localparam int CFG_MODE_LSB = 2;
	localparam int CFG_CLK_LSB = 0;
	localparam int CFG_DIV_LSB = 5;

	// ********************************
	// reset values and encodings
	// ********************************
	localparam logic [4:0] CHAN_RESET = 5'h1f;
	localparam logic [4:0] CHAN_ALL_ONES = 5'h1f;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [1:0] CLK_BUS = 2'h0;
	localparam logic [1:0] CLK_BUS_HALF = 2'h1;
	localparam logic [1:0] CLK_ALT = 2'h2;
	localparam logic [1:0] CLK_ASYNC = 2'h3;
	localparam logic [1:0] MODE_8 = 2'h0;
	localparam logic [1:0] MODE_12 = 2'h1;
	localparam logic [1:0] MODE_10 = 2'h2;

	// ********************************
	// timing
	// ********************************
	localparam int CLOCK_PERIOD_NS = 10;
	localparam int ASYNC_START_NS = 5000;
	localparam int ASYNC_START_CYC = (ASYNC_START_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int ASYNC_DIV = 4;
	localparam int BUS_SETUP_CYC = 5;
	localparam int FIRST_EXTRA_CONVERSION_CLOCK = 3;
	localparam int SAMPLE_SHORT_CONVERSION_CLOCK = 4;
	localparam int SAMPLE_LONG_CONVERSION_CLOCK = 24;
	localparam int APPROX_8_CONVERSION_CLOCK = 13;
	localparam int APPROX_12_CONVERSION_CLOCK = 16;

	typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_WARMUP, ST_SYNC, ST_SAMPLE, ST_CONVERT} acs_state_e;

	// drive seen by one group of port pins
	typedef struct packed {
		logic [23:0] out;
		logic [23:0] oe;
		logic [23:0] pullEn;
		logic [23:0] inEn;
	} acs_pad_s;

endpackage : acs_pkg

// ### src/acs_sequencer.sv
// conversion sequencer: register file, triggers, timing, result transfer, pin isolation
//
// Chosen here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ns
// How it works
// - isolated pin: driver off, pullup off, input buffer off, port read returns zero
// - hardware trigger edge starts a conversion only while trigger select is set
// - trigger edge during a conversion is ignored
// - continuous hardware mode: only the launching edge counts
// - 12, 10 and 8 bit resolutions, with either trigger
// - software mode: first control write starts a conversion unless channel all ones
// - continuous mode restarts after every result transfer until aborted
// - completion loads result registers, sets flag, interrupt if enabled
// - 12/10 bit: high read without low read blocks transfer, result lost
// - single conversion, compare enabled and false: stop, blocking irrelevant
// - any other blocked transfer starts another conversion
// - first control write aborts, then restarts in software mode only, unless channel all ones
// - writes to second control, config or compare registers abort
// - reset aborts; stop entry aborts unless async clock selected
// - abort keeps last results; reset clears them
// - idle until started; async clock enabled only if selected
// - sample 3.5 or 23.5 conversion clocks (4 or 24 here), then approximate
// - first conversion within 20/23 or 40/43 clocks plus 5 bus cycles
// - async source adds up to 5 us startup
// - later continuous conversions take 17/20 or 37/40 clocks
// - exact continuous sample time needs bus clock fast enough
// - module disabled in reset and while channel is all ones
// - compare false at completion: no flag, no transfer
// - clock select 00 picks bus clock, the reset default
// - mode value 10 selects 10 bit
module acs_sequencer (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// avalon-mm slave
	input wire logic [5:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// trigger, power state and clock sources
	input wire logic hwTriggerInput,
	input wire logic stopEntry,
	input wire logic altClkTick,
	// analog front end
	input wire logic [11:0] analogIn,
	output logic [4:0] channelSelect,
	output logic sampleHold,
	output logic asyncClockOn,
	output logic completionIrq,
	// port pins
	input wire acs_pkg::acs_pad_s portDrive,
	input wire logic [23:0] pinIn,
	output acs_pkg::acs_pad_s pinDrive,
	output logic [23:0] portReadData
);
	import acs_pkg::*;

	// ********************************
	// registers and wires
	// ********************************
	logic waitReqQ;
	logic [31:0] readDataQ;
	logic flagQ, irqEnQ, contQ;
	logic [4:0] chanQ;
	logic trigSelQ, cmpEnQ, cmpGtQ;
	logic [7:0] cfgQ;
	logic [3:0] cmpHiQ, resHiQ;
	logic [7:0] cmpLoQ, resLoQ;
	logic [23:0] isoQ;
	logic blockQ;
	acs_state_e stateQ;
	logic [8:0] cntQ;
	logic [11:0] sampledQ;
	logic hwPrevQ;
	logic irqQ, asyncOnQ, holdQ;
	acs_pad_s padQ;
	logic [23:0] portRdQ;

	logic [11:0] analogSync;
	logic hwSync;
	logic [23:0] pinSync;
	logic adckTick;

	logic [3:0] idx;
	logic busWr, busRd;
	logic wrSc1, wrSc2, wrCfg, wrCmpHi, wrCmpLo;
	logic rdResHi, rdResLo;
	logic [1:0] clkSel, modeSel;
	logic disabled, abortNow, hwEdge, swStart, hwStart, startNow;
	logic [8:0] sampleLen, approxLen;
	logic doneEvt, cmpOk, blocked, transfer, restart;
	logic [11:0] convVal, cmpVal, outVal;

	assign idx = address[5:2];
	assign busWr = write && !waitReqQ;
	assign busRd = read && !waitReqQ;
	assign wrSc1 = busWr && (idx == IDX_SC_FIRST);
	assign wrSc2 = busWr && (idx == IDX_SC_SECOND);
	assign wrCfg = busWr && (idx == IDX_CONFIG);
	assign wrCmpHi = busWr && (idx == IDX_CMP_HIGH);
	assign wrCmpLo = busWr && (idx == IDX_CMP_LOW);
	assign rdResHi = busRd && (idx == IDX_RES_HIGH);
	assign rdResLo = busRd && (idx == IDX_RES_LOW);
	assign clkSel = cfgQ[CFG_CLK_LSB +: 2];
	assign modeSel = cfgQ[CFG_MODE_LSB +: 2];

	// ********************************
	// input synchronisers
	// ********************************
	// analog code is sampled only after it has settled for many cycles, so a plain
	// multi-bit two-stage capture is accepted here
	acs_sync2 #(.WIDTH(12)) uAnalogSync (
		.clock(clock),
		.rst_b(rst_b),
		.async(analogIn),
		.sync(analogSync)
	);

	acs_sync2 #(.WIDTH(1)) uTrigSync (
		.clock(clock),
		.rst_b(rst_b),
		.async(hwTriggerInput),
		.sync(hwSync)
	);

	acs_sync2 #(.WIDTH(24)) uPinSync (
		.clock(clock),
		.rst_b(rst_b),
		.async(pinIn),
		.sync(pinSync)
	);

	// conversion clock runs only while active
	acs_clkdiv uClkDiv (
		.clock(clock),
		.rst_b(rst_b),
		.run(stateQ != ST_IDLE),
		.clkSel(clkSel),
		.divSel(cfgQ[CFG_DIV_LSB +: 2]),
		.altTick(altClkTick),
		.adckTick(adckTick)
	);

	// ********************************
	// start and abort decisions
	// ********************************
	always_comb
	begin
		disabled = (chanQ == CHAN_ALL_ONES);
		abortNow = wrSc1 || wrSc2 || wrCfg || wrCmpHi || wrCmpLo;
		if (stopEntry && clkSel != CLK_ASYNC)
			abortNow = 1'b1;
		hwEdge = hwSync && !hwPrevQ;
		swStart = wrSc1 && !trigSelQ && (writedata[4:0] != CHAN_ALL_ONES);
		// edges while busy, including a running continuous chain, fall through
		hwStart = hwEdge && trigSelQ && (stateQ == ST_IDLE) && !disabled && !abortNow;
		startNow = swStart || hwStart;
		sampleLen = cfgQ[CFG_LONG_SAMPLE] ? 9'(SAMPLE_LONG_CONVERSION_CLOCK) : 9'(SAMPLE_SHORT_CONVERSION_CLOCK);
		approxLen = (modeSel == MODE_8) ? 9'(APPROX_8_CONVERSION_CLOCK) : 9'(APPROX_12_CONVERSION_CLOCK);
	end

	// ********************************
	// result shaping and completion
	// ********************************
	always_comb
	begin
		unique case (modeSel)
			MODE_12: convVal = sampledQ;
			MODE_10: convVal = (sampledQ[11:2] == 10'h3ff) ? 12'h3ff
				: {2'h0, sampledQ[11:2] + 10'(sampledQ[1])};
			default: convVal = (sampledQ[11:4] == 8'hff) ? 12'h0ff
				: {4'h0, sampledQ[11:4] + 8'(sampledQ[3])};
		endcase
		cmpVal = {cmpHiQ, cmpLoQ};
		cmpOk = cmpGtQ ? (convVal >= cmpVal) : (convVal < cmpVal);
		outVal = cmpEnQ ? (convVal - cmpVal) : convVal;
		doneEvt = (stateQ == ST_CONVERT) && adckTick && (cntQ == approxLen - 9'h1)
			&& !startNow && !abortNow && !disabled;
		blocked = blockQ && (modeSel != MODE_8);
		transfer = doneEvt && !(cmpEnQ && !cmpOk) && !blocked;
		// blocked results restart even in single mode; single compare miss stops
		if (cmpEnQ && !cmpOk)
			restart = contQ;
		else if (blocked)
			restart = 1'b1;
		else
			restart = contQ;
	end

	// ********************************
	// avalon handshake: one wait cycle, then the edge that completes
	// ********************************
	always_ff @(posedge clock)
	begin
		if (!rst_b)
			waitReqQ <= 1'b1;
		else if ((read || write) && waitReqQ)
			waitReqQ <= 1'b0;
		else
			waitReqQ <= 1'b1;
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
			readDataQ <= '0;
		else if (read && waitReqQ)
		begin
			unique case (idx)
				IDX_SC_FIRST: readDataQ <= {24'h0, flagQ, irqEnQ, contQ, chanQ};
				IDX_SC_SECOND: readDataQ <= {24'h0, stateQ != ST_IDLE, trigSelQ, cmpEnQ,
					cmpGtQ, 4'h0};
				IDX_RES_HIGH: readDataQ <= {28'h0, resHiQ};
				IDX_RES_LOW: readDataQ <= {24'h0, resLoQ};
				IDX_CMP_HIGH: readDataQ <= {28'h0, cmpHiQ};
				IDX_CMP_LOW: readDataQ <= {24'h0, cmpLoQ};
				IDX_CONFIG: readDataQ <= {24'h0, cfgQ};
				IDX_ISO_LOW: readDataQ <= {24'h0, isoQ[7:0]};
				IDX_ISO_MID: readDataQ <= {24'h0, isoQ[15:8]};
				IDX_ISO_HIGH: readDataQ <= {24'h0, isoQ[23:16]};
				default: readDataQ <= '0;
			endcase
		end
	end

	// ********************************
	// control registers
	// ********************************
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			irqEnQ <= 1'b0;
			contQ <= 1'b0;
			chanQ <= CHAN_RESET;
		end
		else if (wrSc1)
		begin
			irqEnQ <= writedata[SC1_IRQ_EN];
			contQ <= writedata[SC1_CONT];
			chanQ <= writedata[4:0];
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			trigSelQ <= 1'b0;
			cmpEnQ <= 1'b0;
			cmpGtQ <= 1'b0;
		end
		else if (wrSc2)
		begin
			trigSelQ <= writedata[SC2_TRIG_SEL];
			cmpEnQ <= writedata[SC2_CMP_EN];
			cmpGtQ <= writedata[SC2_CMP_GT];
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			cfgQ <= CONFIG_RESET;
			cmpHiQ <= '0;
			cmpLoQ <= '0;
			isoQ <= '0;
		end
		else
		begin
			if (wrCfg)
				cfgQ <= writedata[7:0];
			if (wrCmpHi)
				cmpHiQ <= writedata[3:0];
			if (wrCmpLo)
				cmpLoQ <= writedata[7:0];
			if (busWr && idx == IDX_ISO_LOW)
				isoQ[7:0] <= writedata[7:0];
			if (busWr && idx == IDX_ISO_MID)
				isoQ[15:8] <= writedata[7:0];
			if (busWr && idx == IDX_ISO_HIGH)
				isoQ[23:16] <= writedata[7:0];
		end
	end

	// ********************************
	// results, flag and blocking
	// ********************************
	// aborts never touch the results; only reset clears them
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			resHiQ <= '0;
			resLoQ <= '0;
		end
		else if (transfer)
		begin
			resHiQ <= outVal[11:8];
			resLoQ <= outVal[7:0];
		end
	end

	// a completion in the clearing cycle wins
	always_ff @(posedge clock)
	begin
		if (!rst_b)
			flagQ <= 1'b0;
		else if (transfer)
			flagQ <= 1'b1;
		else if (wrSc1 || rdResLo)
			flagQ <= 1'b0;
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
			blockQ <= 1'b0;
		else if (rdResLo)
			blockQ <= 1'b0;
		else if (rdResHi && modeSel != MODE_8)
			blockQ <= 1'b1;
	end

	// ********************************
	// conversion sequence
	// ********************************
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			stateQ <= ST_IDLE;
			cntQ <= '0;
		end
		else if (startNow)
		begin
			stateQ <= ST_SETUP;
			cntQ <= '0;
		end
		else if (abortNow || disabled)
		begin
			stateQ <= ST_IDLE;
			cntQ <= '0;
		end
		else
		begin
			unique case (stateQ)
				ST_IDLE: cntQ <= '0;
				ST_SETUP:
				begin
					cntQ <= cntQ + 9'h1;
					if (cntQ == 9'(BUS_SETUP_CYC - 1))
					begin
						cntQ <= '0;
						stateQ <= (clkSel == CLK_ASYNC) ? ST_WARMUP : ST_SYNC;
					end
				end
				ST_WARMUP:
				begin
					cntQ <= cntQ + 9'h1;
					if (cntQ == 9'(ASYNC_START_CYC - 1))
					begin
						cntQ <= '0;
						stateQ <= ST_SYNC;
					end
				end
				ST_SYNC:
					if (adckTick)
					begin
						cntQ <= cntQ + 9'h1;
						if (cntQ == 9'(FIRST_EXTRA_CONVERSION_CLOCK - 1))
						begin
							cntQ <= '0;
							stateQ <= ST_SAMPLE;
						end
					end
				ST_SAMPLE:
					// bus clock is never slower than its own enable, so timing is exact
					if (adckTick)
					begin
						cntQ <= cntQ + 9'h1;
						if (cntQ == sampleLen - 9'h1)
						begin
							cntQ <= '0;
							stateQ <= ST_CONVERT;
						end
					end
				ST_CONVERT:
					if (adckTick)
					begin
						cntQ <= cntQ + 9'h1;
						if (doneEvt)
						begin
							cntQ <= '0;
							stateQ <= restart ? ST_SAMPLE : ST_IDLE;
						end
					end
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
			sampledQ <= '0;
		else if (stateQ == ST_SAMPLE && adckTick && cntQ == sampleLen - 9'h1)
			sampledQ <= analogSync;
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			hwPrevQ <= 1'b0;
			irqQ <= 1'b0;
			asyncOnQ <= 1'b0;
			holdQ <= 1'b0;
		end
		else
		begin
			hwPrevQ <= hwSync;
			irqQ <= (flagQ || transfer) && irqEnQ;
			asyncOnQ <= (stateQ != ST_IDLE || startNow) && clkSel == CLK_ASYNC;
			holdQ <= (stateQ == ST_SAMPLE);
		end
	end

	// ********************************
	// pin isolation
	// ********************************
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			padQ <= '0;
			portRdQ <= '0;
		end
		else
		begin
			padQ.out <= portDrive.out & ~isoQ;
			padQ.oe <= portDrive.oe & ~isoQ;
			padQ.pullEn <= portDrive.pullEn & ~isoQ;
			padQ.inEn <= portDrive.inEn & ~isoQ;
			portRdQ <= pinSync & ~isoQ;
		end
	end

	assign readdata = readDataQ;
	assign waitrequest = waitReqQ;
	assign channelSelect = chanQ;
	assign sampleHold = holdQ;
	assign asyncClockOn = asyncOnQ;
	assign completionIrq = irqQ;
	assign pinDrive = padQ;
	assign portReadData = portRdQ;

endmodule : acs_sequencer

// ### src/acs_sync2.sv
// two flip-flop synchroniser for levels from outside the clock domain
`timescale 1ns/1ns
module acs_sync2 #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// data
	input wire logic [WIDTH-1:0] async,
	output logic [WIDTH-1:0] sync
);

	logic [WIDTH-1:0] metaQ;

	// first stage feeds only the second
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			metaQ <= '0;
			sync <= '0;
		end
		else
		begin
			metaQ <= async;
			sync <= metaQ;
		end
	end

endmodule : acs_sync2

// ### verification/acs_sequencer_sva.sv
// port assertions for the conversion sequencer
`timescale 1ns/1ns
// ********************************
// checker
// ********************************
module acs_sva (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// register bus
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	// conversion
	input wire logic [4:0] channelSelect,
	input wire logic sampleHold,
	input wire logic asyncClockOn,
	input wire logic completionIrq,
	// pins
	input wire acs_pkg::acs_pad_s portDrive,
	input wire acs_pkg::acs_pad_s pinDrive
);
	import acs_pkg::*;
	// cycles since sampling ended, saturating so it never wraps into a false pass
	logic [9:0] sinceSample_q;
	always_ff @(posedge clock)
	begin
		if (!rst_b || sampleHold)
			sinceSample_q <= 10'h0;
		else if (sinceSample_q != 10'h3ff)
			sinceSample_q <= sinceSample_q + 10'h1;
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	sequence bus_req_s;
		(read || write) && waitrequest;
	endsequence
	sequence sampling_s;
		sampleHold [*4];
	endsequence
	wait_low_a: assert property (bus_req_s |=> !waitrequest) else $error("no answer");
	wait_pulse_a: assert property (!waitrequest |=> waitrequest) else $error("long answer");
	wait_idle_a: assert property (!read && !write |=> waitrequest) else $error("stray answer");
	pad_mask_a: assert property (((pinDrive.out & ~$past(portDrive.out))
		| (pinDrive.oe & ~$past(portDrive.oe)) | (pinDrive.pullEn & ~$past(portDrive.pullEn))
		| (pinDrive.inEn & ~$past(portDrive.inEn))) == 24'h0) else $error("pad not masked");
	reset_a: assert property (disable iff (1'b0) !rst_b |=> waitrequest
		&& readdata == 32'h0 && channelSelect == CHAN_RESET && !completionIrq && !sampleHold
		&& !asyncClockOn && pinDrive == '0) else $error("reset state");
	chan_idle_a: assert property (channelSelect == CHAN_ALL_ONES [*3]
		|-> !sampleHold && !asyncClockOn) else $error("active with channel off");
	sample_len_a: assert property ($rose(sampleHold) |-> sampling_s) else $error("short sample");
	sample_max_a: assert property ($rose(sampleHold) |-> ##[4:800] !sampleHold)
		else $error("endless sample");
	irq_gap_a: assert property ($rose(completionIrq) |-> sinceSample_q >= 10'd10
		&& sinceSample_q < 10'd600) else $error("flag without conversion");
endmodule : acs_sva

// ### verification/test_acs_sequencer.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ns
module test_acs_sequencer;
	import acs_pkg::*;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic [5:0] address = 6'h0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata;
	logic waitrequest;
	logic hwTriggerInput = 1'b0;
	logic stopEntry = 1'b0;
	logic altClkTick = 1'b0;
	logic [11:0] analogIn = 12'h0;
	logic [4:0] channelSelect;
	logic sampleHold, asyncClockOn, completionIrq, seenAsync;
	acs_pad_s portDrive = '0;
	logic [23:0] pinIn = 24'h0;
	acs_pad_s pinDrive;
	logic [23:0] portReadData;
	logic [7:0] rd;
	int num_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	int n;
	// per-mode config, expected result bytes and cycle limits
	logic [7:0] modeCfg [0:5] = '{8'h00, 8'h14, 8'h08, 8'h02, 8'h0b, 8'h21};
	logic [7:0] modeHi [0:5] = '{8'h00, 8'h0a, 8'h02, 8'h00, 8'h02, 8'h00};
	logic [7:0] modeLo [0:5] = '{8'hac, 8'hbc, 8'haf, 8'hac, 8'haf, 8'hac};
	int modeLim [0:5] = '{28, 51, 31, 48, 600, 88};
	logic [3:0] abortIdx [0:3] = '{IDX_CMP_LOW, IDX_CONFIG, IDX_SC_SECOND, IDX_CMP_HIGH};
	logic [7:0] abortVal [0:3] = '{8'h00, 8'h04, 8'h00, 8'h00};
	always #5 clock = ~clock;
	always @(posedge clock) altClkTick <= ~altClkTick;
	// ********************************
	// timeout: whole run is a few thousand cycles
	// ********************************
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			num_errors++;
			tally_and_finish();
		end
	end
	acs_sequencer uut (.clock(clock), .rst_b(rst_b), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.hwTriggerInput(hwTriggerInput), .stopEntry(stopEntry), .altClkTick(altClkTick),
		.analogIn(analogIn), .channelSelect(channelSelect), .sampleHold(sampleHold),
		.asyncClockOn(asyncClockOn), .completionIrq(completionIrq), .portDrive(portDrive),
		.pinIn(pinIn), .pinDrive(pinDrive), .portReadData(portReadData));
	// ********************************
	// bus and compare tasks
	// ********************************
	task chk(input logic [23:0] g, input logic [23:0] e);
		cmp_count++;
		if (g !== e)
		begin
			num_errors++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task chk_max(input int g, input int lim);
		cmp_count++;
		if (g > lim)
		begin
			num_errors++;
			$display("[ERR] %0t took %0d cycles, limit %0d", $time, g, lim);
		end
	endtask : chk_max
	// request held until waitrequest is seen low at an edge
	task bus(input logic wr, input logic [3:0] idx, input logic [7:0] wd);
		@(posedge clock);
		address <= {idx, 2'b00};
		write <= wr;
		read <= ~wr;
		writedata <= {24'h0, wd};
		@(posedge clock);
		while (waitrequest !== 1'b0) @(posedge clock);
		rd = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus
	task wr(input logic [3:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d);
	endtask : wr
	task rdc(input logic [3:0] idx, input logic [7:0] e);
		bus(1'b0, idx, 8'h0);
		chk({16'h0, rd}, {16'h0, e});
	endtask : rdc
	task wait_irq(input int lim);
		n = 0;
		seenAsync = 1'b0;
		// first two edges skipped: a flag cleared by the previous access leaves irq up one cycle
		while ((completionIrq !== 1'b1 || n < 2) && n <= lim)
		begin
			@(posedge clock);
			seenAsync = seenAsync | asyncClockOn;
			n++;
		end
	endtask : wait_irq
	task no_irq();
		wait_irq(60);
		chk({23'h0, completionIrq}, 24'h0);
	endtask : no_irq
	task pulse();
		hwTriggerInput <= 1'b1;
		repeat (3) @(posedge clock);
		hwTriggerInput <= 1'b0;
	endtask : pulse
	// ********************************
	// scenarios
	// ********************************
	task t_reset();
		rdc(IDX_SC_FIRST, {3'h0, CHAN_RESET});
		rdc(IDX_CONFIG, CONFIG_RESET);
		rdc(IDX_RES_LOW, 8'h00);
		wr(4'ha, 8'h55);
		rdc(4'ha, 8'h00);
		chk({19'h0, channelSelect}, {19'h0, CHAN_RESET});
		$display("reset test done");
	endtask : t_reset
	task t_iso();
		portDrive <= {4{24'hffffff}};
		pinIn <= 24'hffffff;
		wr(IDX_ISO_LOW, 8'h0f);
		wr(IDX_ISO_MID, 8'hf0);
		wr(IDX_ISO_HIGH, 8'h81);
		repeat (5) @(posedge clock);
		chk(pinDrive.out, 24'h7e0ff0);
		chk(pinDrive.oe, 24'h7e0ff0);
		chk(pinDrive.pullEn, 24'h7e0ff0);
		chk(pinDrive.inEn, 24'h7e0ff0);
		chk(portReadData, 24'h7e0ff0);
		$display("isolation test done");
	endtask : t_iso
	task t_modes();
		analogIn <= 12'habc;
		for (int i = 0; i < 6; i++)
		begin
			wr(IDX_CONFIG, modeCfg[i]);
			wr(IDX_SC_FIRST, 8'h41);
			wait_irq(modeLim[i]);
			chk_max(n, modeLim[i]);
			chk({23'h0, seenAsync}, {23'h0, i == 4});
			rdc(IDX_RES_HIGH, modeHi[i]);
			rdc(IDX_RES_LOW, modeLo[i]);
		end
		$display("mode test done");
	endtask : t_modes
	task t_block();
		wr(IDX_CONFIG, 8'h04);
		wr(IDX_SC_FIRST, 8'h41);
		wait_irq(31);
		rdc(IDX_RES_HIGH, 8'h0a);
		analogIn <= 12'h123;
		wr(IDX_SC_FIRST, 8'h41);
		no_irq();
		rdc(IDX_RES_LOW, 8'hbc);
		wait_irq(40);
		chk_max(n, 40);
		rdc(IDX_RES_HIGH, 8'h01);
		rdc(IDX_RES_LOW, 8'h23);
		$display("blocking test done");
	endtask : t_block
	task t_abort();
		analogIn <= 12'h555;
		for (int i = 0; i < 4; i++)
		begin
			wr(IDX_SC_FIRST, 8'h41);
			wr(abortIdx[i], abortVal[i]);
			no_irq();
		end
		wr(IDX_SC_FIRST, 8'h41);
		stopEntry <= 1'b1;
		@(posedge clock);
		stopEntry <= 1'b0;
		no_irq();
		rdc(IDX_SC_SECOND, 8'h00);
		rdc(IDX_RES_LOW, 8'h23);
		$display("abort test done");
	endtask : t_abort
	task t_compare();
		wr(IDX_CMP_HIGH, 8'h0f);
		wr(IDX_CMP_LOW, 8'hff);
		wr(IDX_SC_SECOND, 8'h30);
		wr(IDX_SC_FIRST, 8'h41);
		no_irq();
		rdc(IDX_SC_SECOND, 8'h30);
		rdc(IDX_RES_LOW, 8'h23);
		wr(IDX_SC_SECOND, 8'h20);
		wr(IDX_SC_FIRST, 8'h41);
		wait_irq(31);
		chk_max(n, 31);
		rdc(IDX_RES_HIGH, 8'h05);
		rdc(IDX_RES_LOW, 8'h56);
		wr(IDX_SC_SECOND, 8'h00);
		$display("compare test done");
	endtask : t_compare
	task t_hw();
		pulse();
		no_irq();
		wr(IDX_SC_SECOND, 8'h40);
		pulse();
		wait_irq(31);
		chk_max(n, 31);
		rdc(IDX_RES_HIGH, 8'h05);
		rdc(IDX_RES_LOW, 8'h55);
		pulse();
		repeat (6) @(posedge clock);
		pulse();
		wait_irq(31);
		chk_max(n, 20);
		rdc(IDX_RES_HIGH, 8'h05);
		rdc(IDX_RES_LOW, 8'h55);
		no_irq();
		wr(IDX_SC_FIRST, 8'h61);
		pulse();
		wait_irq(31);
		chk_max(n, 31);
		rdc(IDX_RES_HIGH, 8'h05);
		rdc(IDX_RES_LOW, 8'h55);
		wait_irq(25);
		chk_max(n, 14);
		// land the stop write in the approximation phase, after sampling
		repeat (6) @(posedge clock);
		wr(IDX_SC_FIRST, 8'h7f);
		pulse();
		no_irq();
		rst_b <= 1'b0;
		repeat (3) @(posedge clock);
		rst_b <= 1'b1;
		rdc(IDX_RES_LOW, 8'h00);
		$display("trigger test done");
	endtask : t_hw
	task tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		repeat (8) @(posedge clock);
		rst_b <= 1'b1;
		t_reset();
		t_iso();
		t_modes();
		t_block();
		t_abort();
		t_compare();
		t_hw();
		tally_and_finish();
	end
endmodule : test_acs_sequencer
bind acs_sequencer acs_sva chk_i (.clock(clock), .rst_b(rst_b), .read(read), .write(write),
	.readdata(readdata), .waitrequest(waitrequest), .channelSelect(channelSelect),
	.sampleHold(sampleHold), .asyncClockOn(asyncClockOn), .completionIrq(completionIrq),
	.portDrive(portDrive), .pinDrive(pinDrive));
